// File: logic/pae_alarm_eval.sv
// Behaviour
// - type 8 alarms when process value exceeds threshold, setpoint ignored.
// - type 9 alarms when process value is below threshold, setpoint ignored.
// - type 14 alarms when setpoint exceeds threshold.
// - type 15 alarms when setpoint is below threshold.
// - type 16 alarms when output level exceeds threshold.
// - type 17 alarms when output level is below threshold.
// - type 6 is deviation upper limit plus standby.
// - type 7 is deviation lower limit plus standby.
// - type 5 is deviation band alarm plus standby.
// - type 10 is absolute upper limit plus standby.
// - type 11 is absolute lower limit plus standby.
// - type 12 loop-break accepted only on channel 1.
// - position-proportional models refuse loop-break type.
// - type 13 selects rate-of-change alarm; behaviour unspecified, output off.
// - types 1, 4, 5 use separate upper and lower limits.
// - type 5 output off while upper and lower hysteresis bands overlap.
// - heating/cooling: output upper-limit alarm watches heating output only.
// - heating/cooling: output lower-limit alarm watches cooling output only.
// - deviation upper alarms at process value >= setpoint plus threshold.
// - deviation lower alarms at process value <= setpoint minus threshold.
// - band type alarms when process value leaves setpoint-relative band.
// - on and off delays of 0 to 999 seconds on the output.
//
// Our own choices: the register offsets and the strobed register port.
`include "pae_consts.svh"
`default_nettype none
module pae_alarm_eval
  import pae_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PAE_SEC_NS / `PAE_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic sample_valid,
  input wire logic signed [15:0] process_value_in,
  input wire logic signed [15:0] setpoint_value,
  input wire logic signed [15:0] manipulated_output_level,
  input wire logic signed [15:0] cooling_output_level,
  output logic alarm_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic pae_wide_type ext(input logic signed [15:0] v);
    ext = pae_wide_type'(v);
  endfunction

  // held alarms release only past the limit by the hysteresis
  function automatic logic above(input pae_wide_type v, input pae_wide_type lim,
                                 input pae_wide_type hy, input logic held,
                                 input logic incl);
    if (held) begin
      above = v > (lim - hy);
    end else if (incl) begin
      above = v >= lim;
    end else begin
      above = v > lim;
    end
  endfunction

  function automatic logic below(input pae_wide_type v, input pae_wide_type lim,
                                 input pae_wide_type hy, input logic held,
                                 input logic incl);
    if (held) begin
      below = v < (lim + hy);
    end else if (incl) begin
      below = v <= lim;
    end else begin
      below = v < lim;
    end
  endfunction

  function automatic logic is_standby(input logic [4:0] t);
    is_standby = (t == `PAE_T_DEV_BAND_SB) || (t == `PAE_T_DEV_UP_SB) ||
                 (t == `PAE_T_DEV_LO_SB) || (t == `PAE_T_ABS_UP_SB) ||
                 (t == `PAE_T_ABS_LO_SB);
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [4:0] type_r, type_nxt;
  logic signed [15:0] thr_r, thr_nxt, up_r, up_nxt, lo_r, lo_nxt;
  logic signed [15:0] hys_r, hys_nxt;
  logic [9:0] on_dly_r, on_dly_nxt, off_dly_r, off_dly_nxt;
  logic heat_cool_r, heat_cool_nxt, pos_prop_r, pos_prop_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic rej_r, rej_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic type_wr, type_bad;
  logic cond_r, stby_r;
  logic alarm_out_r;

  always_comb begin
    type_nxt = type_r;
    thr_nxt = thr_r;
    up_nxt = up_r;
    lo_nxt = lo_r;
    hys_nxt = hys_r;
    on_dly_nxt = on_dly_r;
    off_dly_nxt = off_dly_r;
    heat_cool_nxt = heat_cool_r;
    pos_prop_nxt = pos_prop_r;
    chan_nxt = chan_r;
    rej_nxt = rej_r;
    rd_data_nxt = 16'h0000;
    type_wr = wr_en && (addr == `PAE_ADDR_TYPE);
    type_bad = (wr_data[4:0] > `PAE_T_MV_LO) || (wr_data[15:5] != 11'h000);
    if (wr_data[4:0] == `PAE_T_LOOP_BREAK) begin
      type_bad = type_bad || (chan_r != `PAE_CHAN_LOOP_BREAK);
      type_bad = type_bad || pos_prop_r;
    end
    if (wr_en) begin
      case (addr)
        `PAE_ADDR_TYPE: begin
          if (!type_bad) begin
            type_nxt = wr_data[4:0];
          end
        end
        `PAE_ADDR_THR: thr_nxt = wr_data;
        `PAE_ADDR_UPPER: up_nxt = wr_data;
        `PAE_ADDR_LOWER: lo_nxt = wr_data;
        `PAE_ADDR_HYST: hys_nxt = wr_data;
        `PAE_ADDR_ON_DLY: begin
          if (wr_data[9:0] <= `PAE_DLY_MAX) begin
            on_dly_nxt = wr_data[9:0];
          end
        end
        `PAE_ADDR_OFF_DLY: begin
          if (wr_data[9:0] <= `PAE_DLY_MAX) begin
            off_dly_nxt = wr_data[9:0];
          end
        end
        `PAE_ADDR_CTRL: begin
          heat_cool_nxt = wr_data[`PAE_CTRL_HEAT_COOL];
          pos_prop_nxt = wr_data[`PAE_CTRL_POS_PROP];
          chan_nxt = wr_data[`PAE_CTRL_CHAN_MSB:`PAE_CTRL_CHAN_LSB];
        end
        `PAE_ADDR_STATUS: begin
          if (wr_data[`PAE_ST_REJECT]) begin
            rej_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a refused write sets the flag even when a clear lands in the same cycle
    if (type_wr && type_bad) begin
      rej_nxt = 1'b1;
    end
    if (rd_en) begin
      case (addr)
        `PAE_ADDR_TYPE: rd_data_nxt = {11'h000, type_r};
        `PAE_ADDR_THR: rd_data_nxt = thr_r;
        `PAE_ADDR_UPPER: rd_data_nxt = up_r;
        `PAE_ADDR_LOWER: rd_data_nxt = lo_r;
        `PAE_ADDR_HYST: rd_data_nxt = hys_r;
        `PAE_ADDR_ON_DLY: rd_data_nxt = {6'h00, on_dly_r};
        `PAE_ADDR_OFF_DLY: rd_data_nxt = {6'h00, off_dly_r};
        `PAE_ADDR_CTRL: begin
          rd_data_nxt[`PAE_CTRL_HEAT_COOL] = heat_cool_r;
          rd_data_nxt[`PAE_CTRL_POS_PROP] = pos_prop_r;
          rd_data_nxt[`PAE_CTRL_CHAN_MSB:`PAE_CTRL_CHAN_LSB] = chan_r;
        end
        `PAE_ADDR_STATUS: begin
          rd_data_nxt[`PAE_ST_ALARM] = alarm_out_r;
          rd_data_nxt[`PAE_ST_STANDBY] = stby_r;
          rd_data_nxt[`PAE_ST_REJECT] = rej_r;
        end
        default: rd_data_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      type_r <= `PAE_TYPE_RESET;
      thr_r <= 16'h0000;
      up_r <= 16'h0000;
      lo_r <= 16'h0000;
      hys_r <= 16'h0000;
      on_dly_r <= 10'h000;
      off_dly_r <= 10'h000;
      heat_cool_r <= 1'b0;
      pos_prop_r <= 1'b0;
      chan_r <= `PAE_CHAN_RESET;
      rej_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      type_r <= type_nxt;
      thr_r <= thr_nxt;
      up_r <= up_nxt;
      lo_r <= lo_nxt;
      hys_r <= hys_nxt;
      on_dly_r <= on_dly_nxt;
      off_dly_r <= off_dly_nxt;
      heat_cool_r <= heat_cool_nxt;
      pos_prop_r <= pos_prop_nxt;
      chan_r <= chan_nxt;
      rej_r <= rej_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;

  // ----------------------------------------
  // evaluation, once per input sample
  // ----------------------------------------
  logic cond_nxt, stby_nxt, raw, overlap;
  logic signed [15:0] sp_last_r, sp_last_nxt;
  logic [4:0] base;
  pae_wide_type pv, sp, thr, up, lo, hy, mv_up, mv_lo;

  always_comb begin
    pv = ext(process_value_in);
    sp = ext(setpoint_value);
    thr = ext(thr_r);
    up = ext(up_r);
    lo = ext(lo_r);
    hy = ext(hys_r);
    mv_up = ext(manipulated_output_level);
    mv_lo = heat_cool_r ? ext(cooling_output_level) : mv_up;
    overlap = (up + lo) < (hy + hy);
    case (type_r)
      `PAE_T_DEV_BAND_SB: base = `PAE_T_DEV_BAND;
      `PAE_T_DEV_UP_SB: base = `PAE_T_DEV_UP;
      `PAE_T_DEV_LO_SB: base = `PAE_T_DEV_LO;
      `PAE_T_ABS_UP_SB: base = `PAE_T_ABS_UP;
      `PAE_T_ABS_LO_SB: base = `PAE_T_ABS_LO;
      default: base = type_r;
    endcase
    case (base)
      `PAE_T_DEV_BAND: raw = above(pv, sp + up, hy, cond_r, 1'b1) ||
                             below(pv, sp - lo, hy, cond_r, 1'b1);
      `PAE_T_DEV_UP: raw = above(pv, sp + thr, hy, cond_r, 1'b1);
      `PAE_T_DEV_LO: raw = below(pv, sp - thr, hy, cond_r, 1'b1);
      `PAE_T_DEV_IN: raw = (pv <= sp + up) && (pv >= sp - lo);
      `PAE_T_ABS_UP: raw = above(pv, thr, hy, cond_r, 1'b0);
      `PAE_T_ABS_LO: raw = below(pv, thr, hy, cond_r, 1'b0);
      `PAE_T_SP_UP: raw = above(sp, thr, hy, cond_r, 1'b0);
      `PAE_T_SP_LO: raw = below(sp, thr, hy, cond_r, 1'b0);
      `PAE_T_MV_UP: raw = above(mv_up, thr, hy, cond_r, 1'b0);
      `PAE_T_MV_LO: raw = below(mv_lo, thr, hy, cond_r, 1'b0);
      // loop-break and rate types are accepted but not evaluated here
      default: raw = 1'b0;
    endcase
    if ((type_r == `PAE_T_DEV_BAND_SB) && overlap) begin
      raw = 1'b0;
    end
    cond_nxt = cond_r;
    stby_nxt = stby_r;
    sp_last_nxt = sp_last_r;
    if (sample_valid) begin
      cond_nxt = raw;
      sp_last_nxt = setpoint_value;
      if (setpoint_value != sp_last_r) begin
        stby_nxt = 1'b1;
      end else if (!raw) begin
        stby_nxt = 1'b0;
      end
    end
    if (type_wr && !type_bad) begin
      stby_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_r <= 1'b0;
      stby_r <= 1'b1;
      sp_last_r <= 16'h0000;
    end else begin
      cond_r <= cond_nxt;
      stby_r <= stby_nxt;
      sp_last_r <= sp_last_nxt;
    end
  end

  // ----------------------------------------
  // on/off delay in whole seconds
  // ----------------------------------------
  pae_out_type st_r, st_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic [31:0] pre_r, pre_nxt;
  logic qual, tick, alarm_out_nxt;
  logic [9:0] dly;

  always_comb begin
    qual = cond_r && !(stby_r && is_standby(type_r));
    tick = pre_r == 32'(TICK_CYCLES - 1);
    pre_nxt = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
    dly = (st_r == pae_on) ? off_dly_r : on_dly_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    // seconds count from the prescaler phase, so a delay may end up to a
    // second short; accuracy traded for a single shared prescaler
    if (qual == (st_r == pae_on)) begin
      cnt_nxt = 10'h000;
    end else if (cnt_r >= dly) begin
      st_nxt = (st_r == pae_on) ? pae_off : pae_on;
      cnt_nxt = 10'h000;
    end else if (tick) begin
      cnt_nxt = cnt_r + 10'h001;
    end
    alarm_out_nxt = st_nxt == pae_on;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= pae_off;
      cnt_r <= 10'h000;
      pre_r <= 32'h0000_0000;
      alarm_out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      alarm_out_r <= alarm_out_nxt;
    end
  end

  assign alarm_out = alarm_out_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_abs_upper_cmp: assert property (
    sample_valid && type_r == `PAE_T_ABS_UP && !cond_r && !type_wr
    |=> cond_r == $past(process_value_in > thr_r))
    else $error("absolute upper compare wrong");

  a_abs_lower_cmp: assert property (
    sample_valid && type_r == `PAE_T_ABS_LO && !cond_r && !type_wr
    |=> cond_r == $past(process_value_in < thr_r))
    else $error("absolute lower compare wrong");

  a_sp_upper_cmp: assert property (
    sample_valid && type_r == `PAE_T_SP_UP && !cond_r && !type_wr
    |=> cond_r == $past(setpoint_value > thr_r))
    else $error("setpoint upper compare wrong");

  a_mv_lower_heat: assert property (
    sample_valid && type_r == `PAE_T_MV_LO && heat_cool_r && !cond_r && !type_wr
    |=> cond_r == $past(cooling_output_level < thr_r))
    else $error("cooling output compare wrong");

  a_loop_break_refused: assert property (
    wr_en && addr == `PAE_ADDR_TYPE && wr_data == {11'h000, `PAE_T_LOOP_BREAK}
    && chan_r != `PAE_CHAN_LOOP_BREAK
    |=> type_r == $past(type_r) && rej_r)
    else $error("loop-break accepted on wrong channel");

  a_overlap_off: assert property (
    sample_valid && type_r == `PAE_T_DEV_BAND_SB && overlap && !type_wr
    |=> !cond_r ##1 !alarm_out_r || $past(alarm_out_r))
    else $error("overlapping band alarm not held off");

  a_standby_mask: assert property (
    stby_r && is_standby(type_r) && st_r == pae_off && on_dly_r == 10'h000
    |=> !alarm_out_r)
    else $error("standby did not suppress alarm");

  a_zero_on_delay: assert property (
    qual && st_r == pae_off && on_dly_r == 10'h000 |=> alarm_out_r)
    else $error("zero on-delay did not switch at once");

  a_type_readback: assert property (
    rd_en && addr == `PAE_ADDR_TYPE |=> rd_data == {11'h000, $past(type_r)})
    else $error("type readback wrong");

endmodule
`default_nettype wire

// File: logic/pae_consts.svh
`ifndef PAE_CONSTS_SVH
`define PAE_CONSTS_SVH
// register offsets
`define PAE_ADDR_TYPE 6'h00
`define PAE_ADDR_THR 6'h04
`define PAE_ADDR_UPPER 6'h08
`define PAE_ADDR_LOWER 6'h0c
`define PAE_ADDR_HYST 6'h10
`define PAE_ADDR_ON_DLY 6'h14
`define PAE_ADDR_OFF_DLY 6'h18
`define PAE_ADDR_CTRL 6'h1c
`define PAE_ADDR_STATUS 6'h20
// control and status fields
`define PAE_CTRL_HEAT_COOL 0
`define PAE_CTRL_POS_PROP 1
`define PAE_CTRL_CHAN_LSB 2
`define PAE_CTRL_CHAN_MSB 3
`define PAE_ST_ALARM 0
`define PAE_ST_STANDBY 1
`define PAE_ST_REJECT 2
// reset values and the loop-break channel
`define PAE_TYPE_RESET 5'h02
`define PAE_CHAN_RESET 2'h1
`define PAE_CHAN_LOOP_BREAK 2'h1
// alarm type codes
`define PAE_T_OFF 5'h00
`define PAE_T_DEV_BAND 5'h01
`define PAE_T_DEV_UP 5'h02
`define PAE_T_DEV_LO 5'h03
`define PAE_T_DEV_IN 5'h04
`define PAE_T_DEV_BAND_SB 5'h05
`define PAE_T_DEV_UP_SB 5'h06
`define PAE_T_DEV_LO_SB 5'h07
`define PAE_T_ABS_UP 5'h08
`define PAE_T_ABS_LO 5'h09
`define PAE_T_ABS_UP_SB 5'h0a
`define PAE_T_ABS_LO_SB 5'h0b
`define PAE_T_LOOP_BREAK 5'h0c
`define PAE_T_RATE 5'h0d
`define PAE_T_SP_UP 5'h0e
`define PAE_T_SP_LO 5'h0f
`define PAE_T_MV_UP 5'h10
`define PAE_T_MV_LO 5'h11
// timing
`define PAE_SEC_NS 1000000000
`define PAE_CLK_PERIOD_NS 10
`define PAE_DLY_MAX 10'h3e7
`endif

// File: logic/pae_pkg.sv
`default_nettype none
package pae_pkg;
  typedef enum logic {pae_off, pae_on} pae_out_type;
  typedef logic signed [17:0] pae_wide_type;
endpackage
`default_nettype wire

// File: testbench/test_process_alarm_evaluator.sv
`include "pae_consts.svh"
`default_nettype none
module test_process_alarm_evaluator;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam int unsigned TICK = 10;
  logic core_clk;
  logic rst_n;
  logic [5:0] addr;
  logic [15:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [15:0] rd_data;
  logic sample_valid;
  logic signed [15:0] process_value_in;
  logic signed [15:0] setpoint_value;
  logic signed [15:0] manipulated_output_level;
  logic signed [15:0] cooling_output_level;
  logic alarm_out;
  int err_total;
  int checks;

  pae_alarm_eval #(.TICK_CYCLES(TICK)) i_pae_alarm_eval (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .sample_valid(sample_valid),
    .process_value_in(process_value_in),
    .setpoint_value(setpoint_value),
    .manipulated_output_level(manipulated_output_level),
    .cooling_output_level(cooling_output_level),
    .alarm_out(alarm_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // returns one cycle after the sample edge, where the output first shows it
  task automatic smp(input int p, input int s, input int m, input int c);
    @(posedge core_clk);
    process_value_in <= 16'(p);
    setpoint_value <= 16'(s);
    manipulated_output_level <= 16'(m);
    cooling_output_level <= 16'(c);
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  function automatic logic exp_alarm(input logic [4:0] t, input int p, input int s, input int m,
                                     input int c, input int x, input int up, input int lo,
                                     input logic hc);
    case (t)
      `PAE_T_DEV_BAND: return (p >= s + up) || (p <= s - lo);
      `PAE_T_DEV_UP: return p >= s + x;
      `PAE_T_DEV_LO: return p <= s - x;
      `PAE_T_DEV_IN: return (p <= s + up) && (p >= s - lo);
      `PAE_T_ABS_UP: return p > x;
      `PAE_T_ABS_LO: return p < x;
      `PAE_T_SP_UP: return s > x;
      `PAE_T_SP_LO: return s < x;
      `PAE_T_MV_UP: return m > x;
      `PAE_T_MV_LO: return (hc ? c : m) < x;
      default: return 1'b0;
    endcase
  endfunction

  function automatic int rnd12();
    return int'($urandom_range(4095)) - 2048;
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    logic [4:0] t;
    logic hc;
    int x, up, lo, p, s, m, c;
    static logic [4:0] plain_t[13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09,
                                       5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11};
    static logic [4:0] sb_t[5] = '{5'h05, 5'h06, 5'h07, 5'h0a, 5'h0b};
    static int sb_on[5] = '{200, 200, -200, 200, -200};
    static int sb_ok[5] = '{0, 0, 0, 0, 200};
    static int cn_t[6] = '{8, 8, 9, 9, 2, 3};
    static int cn_p[6] = '{101, 100, 100, 99, 100, -100};
    static logic cn_e[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    rst_n = 1'b0;
    addr = 6'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    sample_valid = 1'b0;
    process_value_in = 16'sh0000;
    setpoint_value = 16'sh0000;
    manipulated_output_level = 16'sh0000;
    cooling_output_level = 16'sh0000;
    void'($urandom(32'h3b48));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`PAE_ADDR_TYPE, d);
    chk("type after reset", d, 16'h0002);
    rd(`PAE_ADDR_STATUS, d);
    chk("status after reset", d, 16'h0002);
    wr(6'h3c, 16'h00ff);
    rd(6'h3c, d);
    chk("unmapped read", d, 16'h0000);
    rd(`PAE_ADDR_TYPE, d);
    chk("type after unmapped write", d, 16'h0002);
    // boundaries of strict and inclusive compares
    wr(`PAE_ADDR_THR, 16'h0064);
    for (int k = 0; k < 6; k++) begin
      wr(`PAE_ADDR_TYPE, 16'(cn_t[k]));
      chk("corner", 16'(alarm_out), 16'(1'b0));
      smp(cn_p[k], 0, 0, 0);
      chk("corner alarm", 16'(alarm_out), 16'(cn_e[k]));
      // 100 releases a held alarm of every corner type while hysteresis is zero
      smp(100, 0, 0, 0);
    end
    // random configurations over every non-standby code
    for (int i = 0; i < 60; i++) begin
      // clear the held condition so inclusive limits see a fresh compare
      wr(`PAE_ADDR_TYPE, 16'h0000);
      smp(0, 0, 0, 0);
      t = plain_t[$urandom_range(12)];
      hc = 1'($urandom_range(1));
      x = rnd12();
      up = int'($urandom_range(1000));
      lo = int'($urandom_range(1000));
      wr(`PAE_ADDR_CTRL, {14'h0001, 1'b0, hc});
      wr(`PAE_ADDR_TYPE, {11'h000, t});
      wr(`PAE_ADDR_THR, 16'(x));
      wr(`PAE_ADDR_UPPER, 16'(up));
      wr(`PAE_ADDR_LOWER, 16'(lo));
      p = rnd12();
      s = rnd12();
      m = rnd12();
      c = rnd12();
      smp(p, s, m, c);
      chk("random alarm", 16'(alarm_out), 16'(exp_alarm(t, p, s, m, c, x, up, lo, hc)));
    end
    wr(`PAE_ADDR_CTRL, 16'h0005);
    wr(`PAE_ADDR_TYPE, 16'h0011);
    wr(`PAE_ADDR_THR, 16'h0000);
    smp(0, 0, -500, 500);
    chk("cooling output", 16'(alarm_out), 16'h0000);
    // standby sequence types
    wr(`PAE_ADDR_THR, 16'h0064);
    wr(`PAE_ADDR_UPPER, 16'h0064);
    wr(`PAE_ADDR_LOWER, 16'h0064);
    for (int k = 0; k < 5; k++) begin
      smp(sb_on[k], 0, 0, 0);
      wr(`PAE_ADDR_TYPE, {11'h000, sb_t[k]});
      rd(`PAE_ADDR_STATUS, d);
      chk("standby flag", d & 16'h0002, 16'h0002);
      smp(sb_on[k], 0, 0, 0);
      chk("standby hold", 16'(alarm_out), 16'h0000);
      smp(sb_ok[k], 0, 0, 0);
      smp(sb_on[k], 0, 0, 0);
      chk("standby release", 16'(alarm_out), 16'h0001);
    end
    smp(-200, 50, 0, 0);
    chk("setpoint change", 16'(alarm_out), 16'h0000);
    // overlapping hysteresis bands
    wr(`PAE_ADDR_TYPE, 16'h0005);
    wr(`PAE_ADDR_UPPER, 16'h000a);
    wr(`PAE_ADDR_LOWER, 16'h000a);
    wr(`PAE_ADDR_HYST, 16'h0014);
    // second quiet sample clears standby, so only the overlap can hold the alarm off
    smp(0, 0, 0, 0);
    smp(0, 0, 0, 0);
    smp(500, 0, 0, 0);
    chk("overlap off", 16'(alarm_out), 16'h0000);
    wr(`PAE_ADDR_HYST, 16'h0000);
    smp(500, 0, 0, 0);
    chk("band alarm", 16'(alarm_out), 16'h0001);
    // loop-break acceptance
    wr(`PAE_ADDR_TYPE, 16'h0008);
    wr(`PAE_ADDR_CTRL, 16'h0008);
    wr(`PAE_ADDR_TYPE, 16'h000c);
    rd(`PAE_ADDR_TYPE, d);
    chk("type on channel 2", d, 16'h0008);
    rd(`PAE_ADDR_STATUS, d);
    chk("reject flag", d & 16'h0004, 16'h0004);
    wr(`PAE_ADDR_STATUS, 16'h0004);
    rd(`PAE_ADDR_STATUS, d);
    chk("reject cleared", d & 16'h0004, 16'h0000);
    wr(`PAE_ADDR_CTRL, 16'h0006);
    wr(`PAE_ADDR_TYPE, 16'h000c);
    rd(`PAE_ADDR_TYPE, d);
    chk("type position model", d, 16'h0008);
    wr(`PAE_ADDR_CTRL, 16'h0004);
    wr(`PAE_ADDR_TYPE, 16'h000c);
    wr(`PAE_ADDR_TYPE, 16'h0012);
    rd(`PAE_ADDR_TYPE, d);
    chk("type on channel 1", d, 16'h000c);
    // on and off delays, counted in prescaler ticks
    wr(`PAE_ADDR_TYPE, 16'h0008);
    wr(`PAE_ADDR_THR, 16'h0000);
    smp(-100, 0, 0, 0);
    wr(`PAE_ADDR_ON_DLY, 16'h0002);
    wr(`PAE_ADDR_OFF_DLY, 16'h0001);
    wr(`PAE_ADDR_ON_DLY, 16'h03e8);
    rd(`PAE_ADDR_ON_DLY, d);
    chk("on delay limit", d, 16'h0002);
    smp(100, 0, 0, 0);
    repeat (6) @(posedge core_clk);
    #1;
    chk("on delay early", 16'(alarm_out), 16'h0000);
    repeat (24) @(posedge core_clk);
    #1;
    chk("on delay done", 16'(alarm_out), 16'h0001);
    smp(-100, 0, 0, 0);
    chk("off delay early", 16'(alarm_out), 16'h0001);
    repeat (14) @(posedge core_clk);
    #1;
    chk("off delay done", 16'(alarm_out), 16'h0000);
    wrap_up();
  end

  // a hang ends the run as a failure
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
